// ===== bench/module_sideband_control_test.sv
// self-checking bench: host end and module end joined by the pins
`timescale 1ns/1ps
module module_sideband_control_test import msc_pkg::*; ();
  logic        clk = 1'h0, rst_b = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, fault = 1'h0;
  logic        ack, hp, att, prs, rdy;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0, rdo, rdat;
  logic [63:0] q[$], e;
  logic [7:0]  rb;
  int          failures = 0, n_checks = 0, seed = 81;
  msc_sideband_if lnk ();
  msc_host_end #(.QTR_CYC(8)) u_msc_host_end (.clk(clk), .rst_b(rst_b), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(4'hF), .dat_o(rdo),
    .ack_o(ack), .attention(att), .present(prs), .link(lnk));
  msc_module_end #(.RST_MIN_CYC(4), .INIT_CYC(20)) u_msc_module_end (.clk(clk),
    .rst_b(rst_b), .faultEvent(fault), .highPower(hp), .mgmtReady(rdy), .link(lnk));
  msc_properties u_msc_properties (.clk(clk), .rst_b(rst_b),
    .moduleSelectN(lnk.moduleSelectN), .moduleResetN(lnk.moduleResetN),
    .devSdaOe(lnk.devSdaOe), .devIrqOut(lnk.devIrqOut), .devIrqOe(lnk.devIrqOe),
    .sclLine(lnk.sclLine), .sdaLine(lnk.sdaLine), .attentionIrqN(lnk.attentionIrqN),
    .modulePresentN(lnk.modulePresentN), .initControlSelect(lnk.initControlSelect));
  // 50 MHz clock
  always #10 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one classic cycle; a read notes its masked expectation first
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, m, x);
    if (!w) q.push_back({m, x});
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'h1);
    rdat = rdo;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  // poll status until a bit reaches a level; a bounded count guards hangs
  task automatic waitst(input int b, input logic v);
    int n;
    n = 0;
    do begin
      wb(1'h0, HREG_STATUS, 32'h0, 32'h0, 32'h0);
      n++;
    end while (rdat[b] !== v && n < 900);
    // a poll limit that runs out is a failure, not a silent pass
    chk("status wait", 32'(rdat[b]), 32'(v));
  endtask
  task automatic mwr(input logic [7:0] o, d);
    wb(1'h1, HREG_CMD, {16'h0, o, d}, 32'h0, 32'h0);
    waitst(HST_BUSY, 1'h0);
  endtask
  // map read, then nack and read byte checked in status
  task automatic mrd(input logic [7:0] o, x, m);
    wb(1'h1, HREG_CMD, {15'h0, 1'h1, o, 8'h0}, 32'h0, 32'h0);
    waitst(HST_BUSY, 1'h0);
    wb(1'h0, HREG_STATUS, 32'h0, {16'h0, m, 8'h16}, {16'h0, x & m, 8'h14});
  endtask
  // each read answer against the oldest note
  always @(posedge clk) begin
    if (ack === 1'h1 && we === 1'h0) begin
      e = q.pop_front();
      chk("read data", rdo & e[63:32], e[31:0]);
    end
  end
  // hang guard, well beyond the expected run
  initial begin
    #1ms;
    failures++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    waitst(HST_ATTN, 1'h1);
    chk("mgmtReady", 32'(rdy), 32'h1);
    chk("present", 32'(prs), 32'h1);
    chk("attention", 32'(att), 32'h1);
    mrd(MAP_STATUS, 8'h00, 8'h01);
    mrd(MAP_FLAGS, 8'h01, 8'h03);
    chk("attention", 32'(att), 32'h0);
    mrd(MAP_MODE, 8'h03, 8'h03);
    chk("highPower", 32'(hp), 32'h0);
    mwr(MAP_CONTROL, 8'h01);
    chk("highPower", 32'(hp), 32'h1);
    // random scratch bytes round trip
    for (int i = 4; i < 8; i++) begin
      rb = 8'($random(seed));
      mwr(8'(i), rb);
      mrd(8'(i), rb, 8'hFF);
    end
    fault <= 1'h1;
    @(posedge clk);
    fault <= 1'h0;
    waitst(HST_ATTN, 1'h1);
    mrd(MAP_FLAGS, 8'h02, 8'h03);
    // pending fault so the pin reset has an attention to drop
    fault <= 1'h1;
    @(posedge clk);
    fault <= 1'h0;
    // start-up level change refused while present, then a long pin reset
    wb(1'h1, HREG_CTRL, 32'h0, 32'h0, 32'h0);
    wb(1'h0, HREG_CTRL, 32'h0, 32'h3, 32'h2);
    wb(1'h1, HREG_CTRL, 32'h3, 32'h0, 32'h0);
    repeat (20) @(posedge clk);
    chk("mgmtReady", 32'(rdy), 32'h0);
    wb(1'h1, HREG_CTRL, 32'h2, 32'h0, 32'h0);
    waitst(HST_ATTN, 1'h1);
    chk("highPower", 32'(hp), 32'h0);
    mrd(MAP_CONTROL, 8'h00, 8'h01);
    mrd(MAP_MODE, 8'h03, 8'h03);
    // fresh power-up, hardware start-up set before presence is seen
    rst_b <= 1'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    wb(1'h1, HREG_CTRL, 32'h0, 32'h0, 32'h0);
    waitst(HST_ATTN, 1'h1);
    chk("highPower", 32'(hp), 32'h1);
    mrd(MAP_MODE, 8'h00, 8'h03);
    summarize();
  end
endmodule

// ===== bench/msc_properties.sv
// sideband pin checker between host end and module end
`timescale 1ns/1ps
module msc_properties (
  input logic clk,
  input logic rst_b,
  input logic moduleSelectN,
  input logic moduleResetN,
  input logic devSdaOe,
  input logic devIrqOut,
  input logic devIrqOe,
  input logic sclLine,
  input logic sdaLine,
  input logic attentionIrqN,
  input logic modulePresentN,
  input logic initControlSelect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // reset pin low past sync and length filter
  sequence s_longLow; !moduleResetN [*8]; endsequence
  property p_sel; devSdaOe |-> !moduleSelectN; endproperty
  a_sel: assert property (p_sel) else $error("sda driven unselected");
  // bus idle while the start condition is pending
  property p_idle; $fell(moduleSelectN) |-> (sclLine && sdaLine) [*8]; endproperty
  a_idle: assert property (p_idle) else $error("bus busy at select");
  property p_rstHold; s_longLow ##1 !moduleResetN [*4] |-> attentionIrqN; endproperty
  a_rstHold: assert property (p_rstHold) else $error("attention kept in reset");
  property p_rstDone; s_longLow ##1 moduleResetN |-> ##[1:40] !attentionIrqN; endproperty
  a_rstDone: assert property (p_rstDone) else $error("no reset completion");
  property p_pwrUp; $rose(rst_b) |-> ##[1:40] !attentionIrqN; endproperty
  a_pwrUp: assert property (p_pwrUp) else $error("no power-up completion");
  // eight cycles let the host presence filter settle first
  property p_init; !modulePresentN [*8] |-> $stable(initControlSelect); endproperty
  a_init: assert property (p_init) else $error("start-up level moved");
  property p_prs; $past(rst_b, 2) |-> !modulePresentN; endproperty
  a_prs: assert property (p_prs) else $error("presence not low");
  property p_od; devIrqOe |-> !devIrqOut; endproperty
  a_od: assert property (p_od) else $error("attention driven high");
endmodule

// ===== common/msc_pkg.sv
// shared constants and types of the module sideband control link
package msc_pkg;
  // system clock
  localparam int CLK_HZ            = 50_000_000;
  localparam int CLK_MHZ           = CLK_HZ / 1_000_000;
  // least low time on the reset pin before a full reset is taken
  localparam int RST_PULSE_MIN_NS  = 10_000;
  localparam int RST_PULSE_MIN_CYC = (RST_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  // time the management interface needs to come up after a reset
  localparam int MGMT_INIT_NS      = 20_000;
  localparam int MGMT_INIT_CYC     = (MGMT_INIT_NS * CLK_MHZ + 999) / 1000;
  // quarter of a serial clock period, 100 kHz bus
  localparam int SCL_QTR_NS        = 2_500;
  localparam int SCL_QTR_CYC       = SCL_QTR_NS * CLK_MHZ / 1000;

  // serial device address of the module
  localparam logic [6:0] DEV_ADDR  = 7'h50;

  // management memory map offsets and fields
  localparam logic [7:0] MAP_STATUS  = 8'h00;
  localparam logic [7:0] MAP_FLAGS   = 8'h01;
  localparam logic [7:0] MAP_CONTROL = 8'h02;
  localparam logic [7:0] MAP_MODE    = 8'h03;
  localparam int STS_NOT_READY     = 0;
  localparam int FLG_RESET_DONE    = 0;
  localparam int FLG_FAULT         = 1;
  localparam int CTL_HIGH_POWER    = 0;
  localparam int MODE_LOW_POWER    = 0;
  localparam int MODE_SW_CTRL      = 1;
  localparam logic [7:0] CONTROL_RST = 8'h00;

  // host controller register byte addresses and fields
  localparam logic [3:0] HREG_CMD    = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h4;
  localparam logic [3:0] HREG_CTRL   = 4'h8;
  localparam int CMD_WDATA_LSB     = 0;
  localparam int CMD_OFS_LSB       = 8;
  localparam int CMD_READ          = 16;
  localparam int HST_BUSY          = 0;
  localparam int HST_NACK          = 1;
  localparam int HST_PRESENT       = 2;
  localparam int HST_ATTN          = 3;
  localparam int HST_VALID         = 4;
  localparam int HST_RDATA_LSB     = 8;
  localparam int HCT_RESET         = 0;
  localparam int HCT_INIT_SW       = 1;
  localparam logic [1:0] CTRL_RST  = 2'h2;

  typedef enum logic [2:0] {
    SL_IDLE  = 3'b000,
    SL_ADDR  = 3'b001,
    SL_ACK   = 3'b010,
    SL_WDATA = 3'b011,
    SL_WACK  = 3'b100,
    SL_RDATA = 3'b101,
    SL_RACK  = 3'b110
  } msc_slv_t;

  typedef enum logic [1:0] {
    PH_RESET = 2'b00,
    PH_INIT  = 2'b01,
    PH_READY = 2'b10
  } msc_phase_t;

  typedef enum logic [1:0] {
    MS_IDLE  = 2'b00,
    MS_START = 2'b01,
    MS_BIT   = 2'b10,
    MS_STOP  = 2'b11
  } msc_mst_t;
endpackage

// ===== common/msc_sideband_if.sv
// sideband pins between host board and module, pull-ups resolved here
`timescale 1ns/1ps
interface msc_sideband_if;
  logic sclOut;
  logic sclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic moduleSelectN;
  logic moduleResetN;
  logic hostInitOut;
  logic hostInitOe;
  logic devIrqOut;
  logic devIrqOe;
  logic devPresentOut;
  logic devPresentOe;
  logic sclLine;
  logic sdaLine;
  logic initControlSelect;
  logic attentionIrqN;
  logic modulePresentN;

  // open-drain wires float high through pull-ups
  assign sclLine = ~(sclOe & ~sclOut);
  assign sdaLine = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));
  assign initControlSelect = hostInitOe ? hostInitOut : 1'b1; // pulled up
  assign attentionIrqN = ~(devIrqOe & ~devIrqOut);
  assign modulePresentN = devPresentOe ? devPresentOut : 1'b1;

  modport module_end (
    input  sclLine, sdaLine, moduleSelectN, moduleResetN, initControlSelect,
    output devSdaOut, devSdaOe, devIrqOut, devIrqOe, devPresentOut, devPresentOe
  );
  modport host_end (
    input  sdaLine, attentionIrqN, modulePresentN,
    output sclOut, sclOe, hostSdaOut, hostSdaOe, moduleSelectN, moduleResetN,
    output hostInitOut, hostInitOe
  );
endinterface

// ===== hdl/msc_host_end.sv
// host end: wishbone registers driving the sideband pins and a 2-wire master
`timescale 1ns/1ps
module msc_host_end import msc_pkg::*; #(
  parameter int QTR_CYC = SCL_QTR_CYC
) (
  input  logic        clk,
  input  logic        rst_b,
  input  logic        cyc_i,
  input  logic        stb_i,
  input  logic        we_i,
  input  logic [3:0]  adr_i,
  input  logic [31:0] dat_i,
  input  logic [3:0]  sel_i,
  output logic [31:0] dat_o,
  output logic        ack_o,
  output logic        attention,
  output logic        present,
  msc_sideband_if.host_end link
);
  localparam int QW = $clog2(QTR_CYC + 1);
  localparam int HY_PRS = 0;
  localparam int HY_IRQ = 1;
  localparam int HY_SDA = 2;

  if (QTR_CYC < 2) begin : g_chk
    $error("QTR_CYC must be at least 2");
  end

  typedef struct packed {
    logic          ack;
    logic [31:0]   rdat;
    logic [2:0]    syA;
    logic [2:0]    syB;
    logic [2:0]    syC;
    logic [2:0]    filt;
    logic          prsPrev;
    logic          ctlReset;
    logic          ctlInitSw;
    logic          settling;
    logic          cmdRead;
    logic [7:0]    cmdOfs;
    logic [7:0]    cmdData;
    logic          busy;
    logic          nack;
    logic [7:0]    rxData;
    msc_mst_t      mst;
    logic [QW-1:0] qCnt;
    logic [1:0]    q;
    logic [3:0]    bitCnt;
    logic [1:0]    byteIdx;
    logic [7:0]    shift;
    logic          sclLow;
    logic          sdaLow;
  } msc_host_state_t;

  msc_host_state_t s_reg;
  msc_host_state_t s_next;

  // byte sent at each position of a transaction
  function automatic logic [7:0] txByte(input msc_host_state_t st, input logic [1:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == 2'd0) v = {DEV_ADDR, 1'b0};
    if (idx == 2'd1) v = st.cmdOfs;
    if (idx == 2'd2) v = st.cmdRead ? {DEV_ADDR, 1'b1} : st.cmdData;
    return v;
  endfunction

  always_comb begin
    logic req;
    logic tick;
    logic rx;
    logic sda;
    req = cyc_i & stb_i & ~s_reg.ack;
    tick = 1'b0;
    rx = (s_reg.byteIdx == 2'd3);
    sda = s_reg.filt[HY_SDA];
    s_next = s_reg;
    // pin inputs: three flops, change taken once second and third agree
    s_next.syA = {link.sdaLine, link.attentionIrqN, link.modulePresentN};
    s_next.syB = s_reg.syA;
    s_next.syC = s_reg.syB;
    s_next.filt = (s_reg.syC & ~(s_reg.syB ^ s_reg.syC)) | (s_reg.filt & (s_reg.syB ^ s_reg.syC));
    s_next.prsPrev = s_reg.filt[HY_PRS];
    // status is untrustworthy until the completion attention arrives
    if (~s_reg.filt[HY_IRQ] & ~s_reg.ctlReset)
      s_next.settling = 1'b0;
    if (s_reg.ctlReset | (s_reg.prsPrev & ~s_reg.filt[HY_PRS]))
      s_next.settling = 1'b1;
    // wishbone slave, answer one cycle after the request
    s_next.ack = req;
    if (req & we_i) begin
      if (adr_i == HREG_CMD && sel_i[2:0] == 3'h7 && ~s_reg.busy) begin
        s_next.cmdData = dat_i[CMD_WDATA_LSB +: 8];
        s_next.cmdOfs = dat_i[CMD_OFS_LSB +: 8];
        s_next.cmdRead = dat_i[CMD_READ];
        s_next.busy = 1'b1;
        s_next.nack = 1'b0;
        s_next.mst = MS_START;
        s_next.q = 2'd0;
        s_next.qCnt = '0;
        s_next.byteIdx = 2'd0;
      end
      if (adr_i == HREG_CTRL && sel_i[0]) begin
        s_next.ctlReset = dat_i[HCT_RESET];
        // the start-up control level is frozen while a module sits in the slot
        if (s_reg.filt[HY_PRS])
          s_next.ctlInitSw = dat_i[HCT_INIT_SW];
      end
    end
    if (req & ~we_i) begin
      s_next.rdat = 32'h0000_0000;
      if (adr_i == HREG_STATUS) begin
        s_next.rdat[HST_BUSY] = s_reg.busy;
        s_next.rdat[HST_NACK] = s_reg.nack;
        s_next.rdat[HST_PRESENT] = ~s_reg.filt[HY_PRS];
        s_next.rdat[HST_ATTN] = ~s_reg.filt[HY_IRQ]; // source found by a map read
        s_next.rdat[HST_VALID] = ~s_reg.settling;
        s_next.rdat[HST_RDATA_LSB +: 8] = s_reg.rxData;
      end
      if (adr_i == HREG_CTRL) begin
        s_next.rdat[HCT_RESET] = s_reg.ctlReset;
        s_next.rdat[HCT_INIT_SW] = s_reg.ctlInitSw;
      end
    end
    // quarter-period timer of the serial engine
    if (s_reg.mst != MS_IDLE) begin
      if (s_reg.qCnt == QW'(QTR_CYC - 1)) begin
        s_next.qCnt = '0;
        s_next.q = s_reg.q + 2'd1;
        tick = 1'b1;
      end else begin
        s_next.qCnt = s_reg.qCnt + QW'(1);
      end
    end
    if (tick) begin
      case (s_reg.mst)
        MS_START: begin
          // also serves as repeated start: release data while the clock is low
          if (s_reg.q == 2'd0) s_next.sdaLow = 1'b0;
          if (s_reg.q == 2'd1) s_next.sclLow = 1'b0;
          if (s_reg.q == 2'd2) s_next.sdaLow = 1'b1;
          if (s_reg.q == 2'd3) begin
            s_next.sclLow = 1'b1;
            s_next.mst = MS_BIT;
            s_next.bitCnt = 4'd0;
            s_next.shift = txByte(s_reg, s_reg.byteIdx);
          end
        end
        MS_BIT: begin
          if (s_reg.q == 2'd0)
            s_next.sdaLow = ~rx & (s_reg.bitCnt != 4'd8) & ~s_reg.shift[7];
          if (s_reg.q == 2'd1) s_next.sclLow = 1'b0;
          if (s_reg.q == 2'd2) begin
            if (s_reg.bitCnt == 4'd8) begin
              if (~rx) s_next.nack = sda;
            end else if (rx) begin
              s_next.shift = {s_reg.shift[6:0], sda};
            end
          end
          if (s_reg.q == 2'd3) begin
            s_next.sclLow = 1'b1;
            if (s_reg.bitCnt != 4'd8) begin
              s_next.bitCnt = s_reg.bitCnt + 4'd1;
              if (~rx) s_next.shift = {s_reg.shift[6:0], 1'b0};
            end else if (rx) begin
              s_next.rxData = s_reg.shift;
              s_next.mst = MS_STOP;
            end else if (s_reg.nack | (s_reg.byteIdx == 2'd2 & ~s_reg.cmdRead)) begin
              s_next.mst = MS_STOP;
            end else if (s_reg.byteIdx == 2'd1 & s_reg.cmdRead) begin
              s_next.byteIdx = 2'd2;
              s_next.mst = MS_START;
            end else begin
              s_next.byteIdx = s_reg.byteIdx + 2'd1;
              s_next.bitCnt = 4'd0;
              s_next.shift = txByte(s_reg, s_reg.byteIdx + 2'd1);
            end
          end
        end
        MS_STOP: begin
          if (s_reg.q == 2'd0) s_next.sdaLow = 1'b1;
          if (s_reg.q == 2'd1) s_next.sclLow = 1'b0;
          if (s_reg.q == 2'd2) s_next.sdaLow = 1'b0;
          if (s_reg.q == 2'd3) begin
            s_next.mst = MS_IDLE;
            s_next.busy = 1'b0;
          end
        end
        default: s_next.mst = MS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.syA <= 3'h7;
      s_reg.syB <= 3'h7;
      s_reg.syC <= 3'h7;
      s_reg.filt <= 3'h7;
      s_reg.prsPrev <= 1'b1;
      s_reg.ctlReset <= CTRL_RST[HCT_RESET];
      s_reg.ctlInitSw <= CTRL_RST[HCT_INIT_SW];
      s_reg.settling <= 1'b1;
      s_reg.mst <= MS_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // only this module's own select line goes low, and only during its transfer
  assign link.moduleSelectN = ~s_reg.busy;
  assign link.moduleResetN = ~s_reg.ctlReset;
  assign link.hostInitOut = s_reg.ctlInitSw; // high picks software start-up
  assign link.hostInitOe = 1'b1;
  assign link.sclOut = 1'b0;
  assign link.sclOe = s_reg.sclLow;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe = s_reg.sdaLow;
  assign dat_o = s_reg.rdat;
  assign ack_o = s_reg.ack;
  assign attention = ~s_reg.filt[HY_IRQ];
  assign present = ~s_reg.filt[HY_PRS];
endmodule

// ===== hdl/msc_module_end.sv
// module end: 2-wire slave, reset and power start-up, attention output
// Behaviour
// - serial bus answered only while selected
// - host gives each module its own select
// - long reset pulse restores all defaults
// - host ignores status until reset completes
// - completion shown by attention, not-ready cleared
// - power-up raises completion attention unprompted
// - start-up control input pulled high internally
// - high means software, low hardware start-up
// - software control: low power until enabled
// - hardware control: high power once ready
// - host keeps start-up control level fixed; the host end only locks it while a module is present
// - presence pin pulled low by module
// - attention output low reports fault status
// - host finds attention source by map read
// - map read and written over serial bus
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module msc_module_end import msc_pkg::*; #(
  parameter int MAP_BYTES   = 16,
  parameter int RST_MIN_CYC = RST_PULSE_MIN_CYC,
  parameter int INIT_CYC    = MGMT_INIT_CYC
) (
  input  logic clk,
  input  logic rst_b,
  input  logic faultEvent,
  output logic highPower,
  output logic mgmtReady,
  msc_sideband_if.module_end link
);
  localparam int AW = $clog2(MAP_BYTES);
  localparam int CW = 16;
  // bit order of the synchronised pin inputs
  localparam int SY_SCL  = 0;
  localparam int SY_SDA  = 1;
  localparam int SY_SEL  = 2;
  localparam int SY_RST  = 3;
  localparam int SY_INIT = 4;

  if (MAP_BYTES < 8 || MAP_BYTES > 256 || (1 << AW) != MAP_BYTES) begin : g_chk_map
    $error("MAP_BYTES must be a power of two from 8 to 256");
  end
  if (RST_MIN_CYC < 1 || RST_MIN_CYC >= (1 << CW) || INIT_CYC < 1 || INIT_CYC >= (1 << CW))
  begin : g_chk_cnt
    $error("reset and init counts must lie in 1 .. 65535");
  end

  typedef struct packed {
    logic [4:0]                syA;
    logic [4:0]                syB;
    logic [4:0]                syC;
    logic [4:0]                filt;
    logic [4:0]                filtPrev;
    msc_phase_t                phase;
    logic [CW-1:0]             rstCnt;
    logic [CW-1:0]             initCnt;
    msc_slv_t                  slv;
    logic [3:0]                bitCnt;
    logic [7:0]                shift;
    logic [7:0]                ptr;
    logic                      rw;
    logic                      firstByte;
    logic                      masterAck;
    logic                      sdaLow;
    logic                      resetDone;
    logic                      fault;
    logic                      irq;
    logic                      highPower;
    logic [MAP_BYTES-1:0][7:0] mem;
  } msc_dev_state_t;

  msc_dev_state_t s_reg;
  msc_dev_state_t s_next;

  // byte seen by a serial read; status, flags and mode are live views
  function automatic logic [7:0] mapRead(input msc_dev_state_t st, input logic [7:0] ofs);
    logic [7:0] v;
    v = st.mem[ofs[AW-1:0]];
    if (ofs == MAP_STATUS) begin
      v = 8'h00;
      v[STS_NOT_READY] = (st.phase != PH_READY);
    end
    if (ofs == MAP_FLAGS) begin
      v = 8'h00;
      v[FLG_RESET_DONE] = st.resetDone;
      v[FLG_FAULT] = st.fault;
    end
    if (ofs == MAP_MODE) begin
      v = 8'h00;
      v[MODE_LOW_POWER] = ~st.highPower;
      v[MODE_SW_CTRL] = st.filt[SY_INIT];
    end
    return v;
  endfunction

  always_comb begin
    logic sda;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic loadRead;
    sda = s_reg.filt[SY_SDA];
    sclRise = s_reg.filt[SY_SCL] & ~s_reg.filtPrev[SY_SCL];
    sclFall = ~s_reg.filt[SY_SCL] & s_reg.filtPrev[SY_SCL];
    startSeen = s_reg.filt[SY_SCL] & s_reg.filtPrev[SY_SCL] & s_reg.filtPrev[SY_SDA] & ~sda;
    stopSeen = s_reg.filt[SY_SCL] & s_reg.filtPrev[SY_SCL] & ~s_reg.filtPrev[SY_SDA] & sda;
    loadRead = 1'b0;
    s_next = s_reg;
    // pin inputs: three flops, change taken once second and third agree
    s_next.syA = {link.initControlSelect, link.moduleResetN, link.moduleSelectN,
                  link.sdaLine, link.sclLine};
    s_next.syB = s_reg.syA;
    s_next.syC = s_reg.syB;
    s_next.filt = (s_reg.syC & ~(s_reg.syB ^ s_reg.syC)) | (s_reg.filt & (s_reg.syB ^ s_reg.syC));
    s_next.filtPrev = s_reg.filt;

    // serial slave; a deselected module keeps the data line released
    if (s_reg.filt[SY_SEL]) begin
      s_next.slv = SL_IDLE;
      s_next.sdaLow = 1'b0;
    end else if (startSeen) begin
      s_next.slv = SL_ADDR; // only reached while selected
      s_next.bitCnt = 4'd0;
      s_next.sdaLow = 1'b0;
    end else if (stopSeen) begin
      s_next.slv = SL_IDLE;
      s_next.sdaLow = 1'b0;
    end else if (sclRise) begin
      s_next.bitCnt = s_reg.bitCnt + 4'd1;
      if (s_reg.slv == SL_ADDR || s_reg.slv == SL_WDATA)
        s_next.shift = {s_reg.shift[6:0], sda};
      if (s_reg.slv == SL_RACK)
        s_next.masterAck = ~sda;
    end else if (sclFall) begin
      // data changes only while the clock is low
      case (s_reg.slv)
        SL_ADDR: begin
          if (s_reg.bitCnt == 4'd8) begin
            if (s_reg.shift[7:1] == DEV_ADDR) begin
              s_next.slv = SL_ACK;
              s_next.sdaLow = 1'b1;
              s_next.rw = s_reg.shift[0];
              s_next.firstByte = 1'b1;
            end else begin
              s_next.slv = SL_IDLE;
            end
          end
        end
        SL_ACK, SL_WACK: begin
          s_next.bitCnt = 4'd0;
          s_next.sdaLow = 1'b0;
          if (s_reg.rw) loadRead = 1'b1;
          else s_next.slv = SL_WDATA;
        end
        SL_WDATA: begin
          if (s_reg.bitCnt == 4'd8) begin
            s_next.slv = SL_WACK;
            s_next.sdaLow = 1'b1;
            s_next.firstByte = 1'b0;
            // first byte sets the pointer; status, flags and mode are read-only
            if (s_reg.firstByte) begin
              s_next.ptr = s_reg.shift;
            end else begin
              if (s_reg.ptr != MAP_STATUS && s_reg.ptr != MAP_FLAGS && s_reg.ptr != MAP_MODE)
                s_next.mem[s_reg.ptr[AW-1:0]] = s_reg.shift;
              s_next.ptr = s_reg.ptr + 8'd1;
            end
          end
        end
        SL_RDATA: begin
          if (s_reg.bitCnt == 4'd8) begin
            s_next.slv = SL_RACK;
            s_next.sdaLow = 1'b0;
          end else begin
            s_next.shift = {s_reg.shift[6:0], 1'b0};
            s_next.sdaLow = ~s_reg.shift[6];
          end
        end
        SL_RACK: begin
          if (s_reg.masterAck) begin
            loadRead = 1'b1;
          end else begin
            s_next.slv = SL_IDLE;
            s_next.sdaLow = 1'b0;
          end
        end
        default: s_next.slv = SL_IDLE;
      endcase
    end
    // fetch a byte for the master; reading the flags byte clears them
    if (loadRead) begin
      s_next.shift = mapRead(s_reg, s_reg.ptr);
      s_next.sdaLow = ~s_next.shift[7];
      s_next.ptr = s_reg.ptr + 8'd1;
      s_next.slv = SL_RDATA;
      s_next.bitCnt = 4'd0;
      if (s_reg.ptr == MAP_FLAGS) begin
        s_next.resetDone = 1'b0;
        s_next.fault = 1'b0;
      end
    end

    // start-up sequence; power-on enters it without any pin activity
    case (s_reg.phase)
      PH_RESET: begin
        if (s_reg.filt[SY_RST]) begin
          s_next.phase = PH_INIT;
          s_next.initCnt = '0;
        end
      end
      PH_INIT: begin
        if (s_reg.initCnt == CW'(INIT_CYC - 1)) begin
          s_next.phase = PH_READY; // not-ready reads clear from here
          s_next.resetDone = 1'b1;
        end else begin
          s_next.initCnt = s_reg.initCnt + CW'(1);
        end
      end
      PH_READY: s_next.phase = PH_READY;
      default: s_next.phase = PH_RESET;
    endcase
    // fault events are set after the flags-read clear so that a set wins; the long reset pulse clear below still wins
    if (faultEvent)
      s_next.fault = 1'b1;

    // reset pin: short glitches are ignored, a long pulse restores defaults
    if (~s_reg.filt[SY_RST]) begin
      if (s_reg.rstCnt == CW'(RST_MIN_CYC - 1)) begin
        s_next.phase = PH_RESET;
        s_next.mem = '0;
        s_next.mem[MAP_CONTROL[AW-1:0]] = CONTROL_RST;
        s_next.resetDone = 1'b0;
        s_next.fault = 1'b0;
        s_next.slv = SL_IDLE;
        s_next.sdaLow = 1'b0;
        s_next.ptr = 8'h00;
      end else begin
        s_next.rstCnt = s_reg.rstCnt + CW'(1);
      end
    end else begin
      s_next.rstCnt = '0;
    end

    // power mode: software control waits for the enable bit in the map
    if (s_reg.phase != PH_READY)
      s_next.highPower = 1'b0;
    else if (s_reg.filt[SY_INIT]) // high level: software control
      s_next.highPower = s_reg.mem[MAP_CONTROL[AW-1:0]][CTL_HIGH_POWER];
    else
      s_next.highPower = 1'b1;
    s_next.irq = s_next.resetDone | s_next.fault;
  end

  // sync flops idle high: lines pulled up, reset pin released
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.syA <= 5'h1F;
      s_reg.syB <= 5'h1F;
      s_reg.syC <= 5'h1F;
      s_reg.filt <= 5'h1F;
      s_reg.filtPrev <= 5'h1F;
      s_reg.phase <= PH_RESET;
      s_reg.slv <= SL_IDLE;
      s_reg.mem[MAP_CONTROL[AW-1:0]] <= CONTROL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // open-drain outputs only ever pull low
  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe = s_reg.sdaLow;
  assign link.devIrqOut = 1'b0;
  assign link.devIrqOe = s_reg.irq;
  assign link.devPresentOut = 1'b0; // grounds the host pull-up
  assign link.devPresentOe = 1'b1;
  assign highPower = s_reg.highPower;
  assign mgmtReady = (s_reg.phase == PH_READY);
endmodule
